// File: rtl/gige_regs.sv
// Register bank for autonegotiation expansion, next page words and gigabit control and status.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

// Behaviour
// - Parallel detection fault bit 4 latches high until the expansion register is read.
// - Expansion bit 3 shows the link partner is next page capable.
// - Expansion bit 2 reads one: local port supports next pages.
// - Expansion bit 1 latches a received page until the register is read.
// - Expansion bit 0 shows partner autonegotiation ability; bits 15:5 read zero.
// - Next page word: more pages, message page, acknowledge 2, code; resets 0x2001.
// - Transmit toggle bit 11 is inverse of previous transmitted codeword toggle.
// - Received next page register is read-only and mirrors partner's word, reset zero.
// - Received bit 12 reads one when partner complies with the request.
// - Test mode field 15:13 selects normal or modes 1 to 4; higher reserved.
// - Master/slave value bit 11 is honoured only while manual bit 12 is set.
// - Gigabit full and half duplex advertised from bits 9 and 8; reset one.
// - Status bit 15 latches master/slave configuration fault until read.
// - Status bit 14 shows master resolution, reset one, gigabit copper only.
// - Resolution bit keeps the initial result despite later timing role swaps.
// - Status bit 13 shows local receiver operating normally.
// - Status bit 12 shows remote receiver is OK.
// - Status bits 11 and 10 show partner gigabit full and half duplex.
// - Registers are 16 bits; latched bits hold until read, then follow condition.
module gige_regs (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // Negotiation engine status
  input  wire logic        parallel_fault,
  input  wire logic        link_partner_np_able,
  input  wire logic        page_received,
  input  wire logic        link_partner_an_able,
  input  wire logic        codeword_sent,
  input  wire logic        codeword_toggle,
  input  wire logic        partner_page_valid,
  input  wire logic [15:0] partner_page,
  input  wire logic        resolution_valid,
  input  wire logic        resolved_master,
  input  wire logic        ms_config_fault,
  input  wire logic        local_rx_ok,
  input  wire logic        remote_rx_ok,
  input  wire logic        link_partner_gig_fdx,
  input  wire logic        link_partner_gig_hdx,
  input  wire logic        idle_error,
  // Controls to the negotiation engine and PMA
  output logic      [2:0]  test_mode,
  output logic             force_ms,
  output logic             force_master,
  output logic             adv_gig_fdx,
  output logic             adv_gig_hdx,
  output logic             multi_port,
  output logic      [15:0] np_word
);

  // ****************************************************************
  // Decode and carrier
  // ****************************************************************
  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_offset);
    hit = (a == reg_offset);
  endfunction

  // Software and the engine see the same transmit word, with the toggle spliced in.
  function automatic logic [15:0] tx_view(input logic [15:0] word, input logic toggle);
    tx_view = {word[15:12], toggle, word[10:0]};
  endfunction

  status_if st ();

  status_latch status_latch_i (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .st      (st)
  );

  logic [15:0] np_transmit;
  logic [15:0] gig_control;
  logic        tx_toggle;
  logic [15:0] partner_word;
  logic        ms_resolution;
  logic        resolution_seen;
  logic [15:0] next_rdata;

  assign st.fault_event    = parallel_fault;
  assign st.ms_fault_event = ms_config_fault;
  assign st.page_event     = page_received;
  assign st.idle_error     = idle_error;
  assign st.clr_expansion  = reg_read && hit(reg_addr, gige_regs_pkg::ADDR_EXPANSION);
  assign st.clr_status     = reg_read && hit(reg_addr, gige_regs_pkg::ADDR_GIG_STATUS);

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      np_transmit <= gige_regs_pkg::NP_TRANSMIT_RESET;
    end else if (reg_write && hit(reg_addr, gige_regs_pkg::ADDR_NP_TRANSMIT)) begin
      np_transmit <= reg_wdata & gige_regs_pkg::NP_TRANSMIT_WMASK;
    end
  end

  // The whole control word is read/write; reserved bits 7:0 simply store.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gig_control <= gige_regs_pkg::GIG_CONTROL_RESET;
    end else if (reg_write && hit(reg_addr, gige_regs_pkg::ADDR_GIG_CONTROL)) begin
      gig_control <= reg_wdata & gige_regs_pkg::GIG_CONTROL_WMASK;
    end
  end

  // ****************************************************************
  // Engine-fed state
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_toggle <= 1'b0;
    end else if (codeword_sent) begin
      tx_toggle <= ~codeword_toggle;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      partner_word <= 16'h0000;
    end else if (partner_page_valid) begin
      partner_word <= partner_page;
    end
  end

  // Only the first resolution after reset is captured, so a later swap of the
  // timing roles leaves the result reported in status bit 14 alone.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ms_resolution   <= 1'b1;
      resolution_seen <= 1'b0;
    end else if (resolution_valid && !resolution_seen) begin
      ms_resolution   <= resolved_master;
      resolution_seen <= 1'b1;
    end
  end

  // ****************************************************************
  // Controls out
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      test_mode <= 3'h0;
    end else if (gig_control[15:13] > gige_regs_pkg::TEST_DISTORTION) begin
      test_mode <= 3'h0;
    end else begin
      test_mode <= gig_control[15:13];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      force_ms     <= 1'b0;
      force_master <= 1'b0;
    end else begin
      force_ms     <= gig_control[gige_regs_pkg::CTL_MANUAL_BIT];
      force_master <= gig_control[gige_regs_pkg::CTL_MANUAL_BIT] & gig_control[gige_regs_pkg::CTL_MSVAL_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      adv_gig_fdx <= 1'b1;
      adv_gig_hdx <= 1'b1;
      multi_port  <= 1'b1;
    end else begin
      adv_gig_fdx <= gig_control[gige_regs_pkg::CTL_FDX_BIT];
      adv_gig_hdx <= gig_control[gige_regs_pkg::CTL_HDX_BIT];
      multi_port  <= gig_control[gige_regs_pkg::CTL_PORT_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      np_word <= gige_regs_pkg::NP_TRANSMIT_RESET;
    end else begin
      np_word <= tx_view(np_transmit, tx_toggle);
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      gige_regs_pkg::ADDR_EXPANSION: begin
        next_rdata[gige_regs_pkg::EXP_PDF_BIT]    = st.pdf_latched;
        next_rdata[gige_regs_pkg::EXP_LPNP_BIT]   = link_partner_np_able;
        next_rdata[gige_regs_pkg::EXP_LOCNP_BIT]  = 1'b1;
        next_rdata[gige_regs_pkg::EXP_PAGERX_BIT] = st.page_latched;
        next_rdata[gige_regs_pkg::EXP_LPAN_BIT]   = link_partner_an_able;
      end
      gige_regs_pkg::ADDR_NP_TRANSMIT: begin
        next_rdata = tx_view(np_transmit, tx_toggle);
      end
      gige_regs_pkg::ADDR_NP_RECEIVE: begin
        next_rdata = partner_word;
      end
      gige_regs_pkg::ADDR_GIG_CONTROL: begin
        next_rdata = gig_control;
      end
      gige_regs_pkg::ADDR_GIG_STATUS: begin
        next_rdata[gige_regs_pkg::ST_FAULT_BIT]  = st.ms_fault_latched;
        next_rdata[gige_regs_pkg::ST_MASTER_BIT] = ms_resolution;
        next_rdata[gige_regs_pkg::ST_LOCRX_BIT]  = local_rx_ok;
        next_rdata[gige_regs_pkg::ST_REMRX_BIT]  = remote_rx_ok;
        next_rdata[gige_regs_pkg::ST_LPFDX_BIT]  = link_partner_gig_fdx;
        next_rdata[gige_regs_pkg::ST_LPHDX_BIT]  = link_partner_gig_hdx;
        next_rdata[7:0]                          = st.idle_count;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Read answers are checked one cycle after the strobe that asked for them, through $past or through |=>.
  a_pdf_read_back: assert property (@(posedge clk_sys) disable iff (!reset_n)
    parallel_fault ##1 reg_read && hit(reg_addr, gige_regs_pkg::ADDR_EXPANSION)
    |=> reg_rdata[4])
    else $error("parallel fault not reported");

  a_exp_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(reg_read) && $past(reg_addr) == gige_regs_pkg::ADDR_EXPANSION
    |-> reg_rdata[15:5] == 11'h000 && reg_rdata[2])
    else $error("expansion reserved or local bit wrong");

  a_expansion_live: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(reg_read) && $past(reg_addr) == gige_regs_pkg::ADDR_EXPANSION
    |-> reg_rdata[3] == $past(link_partner_np_able) && reg_rdata[0] == $past(link_partner_an_able))
    else $error("partner abilities not shown in expansion");

  a_page_latch_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    page_received ##1 reg_read && hit(reg_addr, gige_regs_pkg::ADDR_EXPANSION)
    |=> reg_rdata[1])
    else $error("page received not latched");

  a_toggle_inverse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    codeword_sent |=> tx_toggle == !$past(codeword_toggle))
    else $error("toggle not inverted");

  a_tx_readback: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(reg_read) && $past(reg_addr) == gige_regs_pkg::ADDR_NP_TRANSMIT
    |-> reg_rdata[14] == 1'b0 && reg_rdata[11] == $past(tx_toggle))
    else $error("transmit page reserved or toggle bit wrong");

  a_tx_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_write && hit(reg_addr, gige_regs_pkg::ADDR_NP_TRANSMIT) |=> np_transmit == ($past(reg_wdata) & 16'hB7FF))
    else $error("transmit page write not stored under its mask");

  a_np_word_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> np_word[15:12] == $past(np_transmit[15:12]) && np_word[10:0] == $past(np_transmit[10:0])
    && np_word[11] == $past(tx_toggle))
    else $error("transmitted next page word stale");

  a_np_readonly: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !partner_page_valid |=> $stable(partner_word))
    else $error("received page changed without a page");

  a_partner_capture: assert property (@(posedge clk_sys) disable iff (!reset_n)
    partner_page_valid |=> partner_word == $past(partner_page))
    else $error("partner page not captured");

  a_control_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_write && hit(reg_addr, gige_regs_pkg::ADDR_GIG_CONTROL) |=> gig_control == $past(reg_wdata))
    else $error("control write not stored");

  a_test_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
    gig_control[15:13] > 3'h4 |=> test_mode == 3'h0)
    else $error("reserved test mode applied");

  a_test_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    gig_control[15:13] < 3'h5 |=> test_mode == $past(gig_control[15:13]))
    else $error("test mode not applied");

  a_ms_manual: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !gig_control[12] |=> !force_master && !force_ms)
    else $error("master forced without manual enable");

  a_ms_forced: assert property (@(posedge clk_sys) disable iff (!reset_n)
    gig_control[12] |=> force_ms && force_master == $past(gig_control[11]))
    else $error("manual master/slave value not honoured");

  a_adv_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> adv_gig_fdx == $past(gig_control[9]) && adv_gig_hdx == $past(gig_control[8]))
    else $error("advertised gigabit duplex stale");

  a_ms_fault_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ms_config_fault ##1 reg_read && hit(reg_addr, gige_regs_pkg::ADDR_GIG_STATUS)
    |=> reg_rdata[15])
    else $error("master/slave fault not latched");

  a_resolution_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
    resolution_valid && !resolution_seen |=> ms_resolution == $past(resolved_master))
    else $error("first resolution not captured");

  a_resolution_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
    resolution_seen |=> $stable(ms_resolution))
    else $error("resolution changed after first result");

  a_status_live: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(reg_read) && $past(reg_addr) == gige_regs_pkg::ADDR_GIG_STATUS
    |-> reg_rdata[13] == $past(local_rx_ok) && reg_rdata[12] == $past(remote_rx_ok) && reg_rdata[9:8] == 2'b00
    && reg_rdata[11] == $past(link_partner_gig_fdx) && reg_rdata[10] == $past(link_partner_gig_hdx))
    else $error("receiver or partner gigabit status not shown");

  a_idle_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_read && hit(reg_addr, gige_regs_pkg::ADDR_GIG_STATUS) && !idle_error |=> st.idle_count == 8'h00)
    else $error("idle error count not cleared by read");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(reg_read) && $past(reg_addr) > gige_regs_pkg::ADDR_GIG_STATUS |-> reg_rdata == 16'h0000)
    else $error("unmapped register read not zero");

  a_read_one_cycle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !reg_read |=> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");

endmodule

// File: rtl/gige_regs_pkg.sv
// Package with register offsets, field positions and reset values of the gigabit register group.
package gige_regs_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [4:0] ADDR_EXPANSION    = 5'h06;
  localparam logic [4:0] ADDR_NP_TRANSMIT  = 5'h07;
  localparam logic [4:0] ADDR_NP_RECEIVE   = 5'h08;
  localparam logic [4:0] ADDR_GIG_CONTROL  = 5'h09;
  localparam logic [4:0] ADDR_GIG_STATUS   = 5'h0A;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int EXP_PDF_BIT     = 4;
  localparam int EXP_LPNP_BIT    = 3;
  localparam int EXP_LOCNP_BIT   = 2;
  localparam int EXP_PAGERX_BIT  = 1;
  localparam int EXP_LPAN_BIT    = 0;
  localparam int NP_MORE_BIT     = 15;
  localparam int NP_ACK_BIT      = 14;
  localparam int NP_MSG_BIT      = 13;
  localparam int NP_ACK2_BIT     = 12;
  localparam int NP_TOGGLE_BIT   = 11;
  localparam int CTL_TEST_LSB    = 13;
  localparam int CTL_MANUAL_BIT  = 12;
  localparam int CTL_MSVAL_BIT   = 11;
  localparam int CTL_PORT_BIT    = 10;
  localparam int CTL_FDX_BIT     = 9;
  localparam int CTL_HDX_BIT     = 8;
  localparam int ST_FAULT_BIT    = 15;
  localparam int ST_MASTER_BIT   = 14;
  localparam int ST_LOCRX_BIT    = 13;
  localparam int ST_REMRX_BIT    = 12;
  localparam int ST_LPFDX_BIT    = 11;
  localparam int ST_LPHDX_BIT    = 10;

  // ****************************************************************
  // Reset values, write masks, idle count limit and test modes
  // ****************************************************************
  localparam logic [15:0] NP_TRANSMIT_RESET = 16'h2001;
  localparam logic [15:0] NP_TRANSMIT_WMASK = 16'hB7FF;
  localparam logic [15:0] GIG_CONTROL_RESET = 16'h0700;
  localparam logic [15:0] GIG_CONTROL_WMASK = 16'hFFFF;
  localparam logic [7:0]  IDLE_COUNT_MAX    = 8'hFF;

  typedef enum logic [2:0] {
    TEST_NORMAL,
    TEST_WAVEFORM,
    TEST_JITTER_MASTER,
    TEST_JITTER_SLAVE,
    TEST_DISTORTION
  } test_mode_t;

endpackage

// File: rtl/status_if.sv
// Interface carrying negotiation status between the register bank and its latch module.
`timescale 1ns/1ps
interface status_if;
  logic       fault_event;
  logic       ms_fault_event;
  logic       page_event;
  logic       idle_error;
  logic       clr_expansion;
  logic       clr_status;
  logic       pdf_latched;
  logic       page_latched;
  logic       ms_fault_latched;
  logic [7:0] idle_count;

  modport bank (
    output fault_event, ms_fault_event, page_event, idle_error, clr_expansion, clr_status,
    input  pdf_latched, page_latched, ms_fault_latched, idle_count
  );
  modport latch (
    input  fault_event, ms_fault_event, page_event, idle_error, clr_expansion, clr_status,
    output pdf_latched, page_latched, ms_fault_latched, idle_count
  );
endinterface

// File: rtl/status_latch.sv
// Sticky status bits and saturating idle error counter, cleared by management reads.
`timescale 1ns/1ps
module status_latch (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Status carrier
  status_if.latch  st
);

  // An event in the read cycle survives: the set term wins over the clear.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st.pdf_latched <= 1'b0;
    end else begin
      st.pdf_latched <= st.fault_event | (st.pdf_latched & ~st.clr_expansion);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st.page_latched <= 1'b0;
    end else begin
      st.page_latched <= st.page_event | (st.page_latched & ~st.clr_expansion);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st.ms_fault_latched <= 1'b0;
    end else begin
      st.ms_fault_latched <= st.ms_fault_event | (st.ms_fault_latched & ~st.clr_status);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st.idle_count <= 8'h00;
    end else if (st.clr_status) begin
      st.idle_count <= st.idle_error ? 8'h01 : 8'h00;
    end else if (st.idle_error && st.idle_count != gige_regs_pkg::IDLE_COUNT_MAX) begin
      st.idle_count <= st.idle_count + 8'h01;
    end
  end

  a_pdf_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st.pdf_latched && !st.clr_expansion |=> st.pdf_latched)
    else $error("parallel fault flag dropped without a read");

  a_idle_saturate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st.idle_count == 8'hFF && !st.clr_status |=> st.idle_count == 8'hFF)
    else $error("idle error count wrapped");

endmodule

// File: verif/mgmt_master.sv
// Management station model that issues register writes and reads.
`timescale 1ns/1ps
module mgmt_master (
  // Clock
  input  wire logic        clk_sys,
  // Register port
  output logic      [4:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_write,
  output logic             reg_read,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr  <= 5'h1F;
    reg_wdata <= 16'h0000;
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Released lines are inverted so that a late sample never sees the old value.
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    // The answer stands for the whole cycle after the strobe; take it at the edge that ends it.
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
endmodule

// File: verif/autoneg_nextpage_gige_ctrl_status_test.sv
// Self-checking bench for the gigabit register group.
`timescale 1ns/1ps
module autoneg_nextpage_gige_ctrl_status_test;
  logic        clk_sys, reset_n;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, np_word, pp;
  logic        reg_write, reg_read, force_ms, force_master;
  logic        adv_gig_fdx, adv_gig_hdx, multi_port;
  logic [2:0]  test_mode;
  logic [6:0]  ev;
  logic [7:0]  lv;
  int          n_fail, num_checks, cycles;

  mgmt_master mgmt_master_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

  gige_regs gige_regs_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .parallel_fault(ev[0]), .link_partner_np_able(lv[0]), .page_received(ev[1]),
    .link_partner_an_able(lv[1]), .codeword_sent(ev[2]), .codeword_toggle(lv[2]),
    .partner_page_valid(ev[3]), .partner_page(pp), .resolution_valid(ev[4]),
    .resolved_master(lv[3]), .ms_config_fault(ev[5]), .local_rx_ok(lv[4]), .remote_rx_ok(lv[5]),
    .link_partner_gig_fdx(lv[6]), .link_partner_gig_hdx(lv[7]), .idle_error(ev[6]),
    .test_mode(test_mode), .force_ms(force_ms), .force_master(force_master),
    .adv_gig_fdx(adv_gig_fdx), .adv_gig_hdx(adv_gig_hdx), .multi_port(multi_port),
    .np_word(np_word));

  // ****************************************************************
  // Clock, reset and run limit
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task print_verdict();
    $display("comparisons %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task rdc(input logic [4:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    mgmt_master_i.rd(a, d);
    check(what, d, exp);
  endtask

  // Event inputs are single-cycle pulses.
  task pulse(input int b);
    @(posedge clk_sys);
    ev[b] <= 1'b1;
    @(posedge clk_sys);
    ev[b] <= 1'b0;
  endtask

  function automatic logic [15:0] ctl();
    return {test_mode, force_ms, force_master, multi_port, adv_gig_fdx, adv_gig_hdx, 8'h00};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset();
    rdc(5'h06, 16'h0004, "expansion");
    rdc(5'h07, 16'h2001, "np_transmit");
    rdc(5'h08, 16'h0000, "np_receive");
    rdc(5'h09, 16'h0700, "control");
    rdc(5'h0A, 16'h4000, "status");
    rdc(5'h1F, 16'h0000, "unmapped");
    check("control outputs", ctl(), 16'h0700);
    check("np_word", np_word, 16'h2001);
  endtask

  task t_expansion();
    @(posedge clk_sys);
    lv[1:0] <= 2'b11;
    pulse(0);
    pulse(1);
    rdc(5'h06, 16'h001F, "expansion set");
    rdc(5'h06, 16'h000D, "expansion after read");
    mgmt_master_i.wr(5'h06, 16'hFFFF);
    rdc(5'h06, 16'h000D, "expansion written");
    @(posedge clk_sys);
    lv[1:0] <= 2'b00;
    rdc(5'h06, 16'h0004, "expansion idle");
  endtask

  task t_np_transmit();
    mgmt_master_i.wr(5'h07, 16'hFFFF);
    rdc(5'h07, 16'hB7FF, "np_transmit written");
    check("np_word", np_word, 16'hB7FF);
    @(posedge clk_sys);
    lv[2] <= 1'b0;
    pulse(2);
    rdc(5'h07, 16'hBFFF, "toggle after 0");
    check("np_word toggled", np_word, 16'hBFFF);
    @(posedge clk_sys);
    lv[2] <= 1'b1;
    pulse(2);
    rdc(5'h07, 16'hB7FF, "toggle after 1");
  endtask

  task t_np_receive();
    @(posedge clk_sys);
    pp <= 16'h1234;
    pulse(3);
    @(posedge clk_sys);
    pp <= 16'h6FFF;
    rdc(5'h08, 16'h1234, "np_receive");
    mgmt_master_i.wr(5'h08, 16'hFFFF);
    rdc(5'h08, 16'h1234, "np_receive written");
    pulse(3);
    rdc(5'h08, 16'h6FFF, "np_receive second");
  endtask

  // Media sensing is outside this block, so software has nothing to turn off first.
  task t_control();
    logic [2:0]  c;
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      d = {c, c[1:0], c, 8'hA5};
      mgmt_master_i.wr(5'h09, d);
      rdc(5'h09, d, "control readback");
      check("control outputs", ctl(), {(c < 3'h5) ? c : 3'h0, c[1], c[1] & c[0], c, 8'h00});
    end
    mgmt_master_i.wr(5'h09, 16'h0700);
  endtask

  task t_status();
    @(posedge clk_sys);
    lv[7:3] <= 5'b01010;
    pulse(4);
    @(posedge clk_sys);
    lv[3] <= 1'b1;
    pulse(4);
    pulse(5);
    repeat (3) pulse(6);
    rdc(5'h0A, 16'hA803, "status set");
    rdc(5'h0A, 16'h2800, "status after read");
    @(posedge clk_sys);
    lv[7:4] <= 4'b1010;
    repeat (260) pulse(6);
    rdc(5'h0A, 16'h14FF, "status saturated");
    mgmt_master_i.wr(5'h0A, 16'hFFFF);
    rdc(5'h0A, 16'h1400, "status written");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    n_fail = 0;
    num_checks = 0;
    cycles = 0;
    reset_n <= 1'b0;
    ev <= 7'h00;
    lv <= 8'h00;
    pp <= 16'h0000;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_expansion();
    t_np_transmit();
    t_np_receive();
    t_control();
    t_status();
    print_verdict();
  end
endmodule
